//--- hw/stp_pkg.sv
// Constants for the system tick prescaler chain.
// Assumes an AXI4-Lite master and a 20 MHz system clock.
// Functional notes
// - One instruction cycle is four clocks; slow arithmetic takes sixteen clocks.
// - Instruction cycle length is fixed at four clocks, never selectable.
// - Microsecond tick divides system clock by us_divisor plus one.
// - With pwm_clk_select clear, the microsecond tick is the PWM input clock.
// - Selected PWM input clock is divided by the PWM period registers plus one.
// - Flash-write clock period is (flash_timing_ctrl[3:0]+1)*5 microsecond ticks.
// - Millisecond tick divides system clock by 16-bit ms divisor plus one.
// - Millisecond interrupt needs ms_irq_enable and aux_irq_global_enable both set.
// - Millisecond interrupt fires every interval plus one millisecond ticks.
// - Interval write with bit 7 set loads at once, else at expiry.
// - Hundred-millisecond tick after tenth_second_divisor plus one millisecond ticks.
// - Hundred-millisecond tick is driven out on the tenth_second_tick port.
// - Millisecond tick is also the flash erase time base.
package stp_pkg;
    // Register indices; the byte address is the index times four
    localparam logic [7:0] ADDR_MS_IRQ_INTERVAL_IDX = 8'hfa;
    localparam logic [7:0] ADDR_US_DIVISOR_IDX = 8'hfb;
    localparam logic [7:0] ADDR_MS_DIVISOR_LOW_IDX = 8'hfc;
    localparam logic [7:0] ADDR_MS_DIVISOR_HIGH_IDX = 8'hfd;
    localparam logic [7:0] ADDR_TENTH_SECOND_DIVISOR_IDX = 8'hfe;
    localparam logic [7:0] ADDR_FLASH_TIMING_CTRL_IDX = 8'he0;
    localparam logic [7:0] ADDR_PWM_CONTROL_IDX = 8'he1;
    localparam logic [7:0] ADDR_PWM_PERIOD_LOW_IDX = 8'he2;
    localparam logic [7:0] ADDR_PWM_PERIOD_HIGH_IDX = 8'he3;
    localparam logic [7:0] ADDR_AUX_IRQ_ENABLE_IDX = 8'he4;
    localparam logic [7:0] ADDR_EXT_IRQ_CONTROL_IDX = 8'he5;
    localparam logic [7:0] ADDR_TICK_STATUS_IDX = 8'he6;
    localparam int ADDR_W = 10;
    // Field positions
    localparam int PWM_CLK_SELECT_BIT = 3;
    localparam int MS_IRQ_ENABLE_BIT = 4;
    localparam int AUX_IRQ_GLOBAL_ENABLE_BIT = 5;
    localparam int MS_IRQ_LOAD_NOW_BIT = 7;
    localparam int FLASH_TIMING_MSB = 3;
    // Reset values
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [7:0] US_DIVISOR_RESET = 8'h13;
    localparam logic [15:0] MS_DIVISOR_RESET = 16'h4e1f;
    localparam logic [7:0] TENTH_RESET = 8'h63;
    // Instruction cycle timing
    localparam logic [1:0] INSN_PHASE_LAST = 2'h3;
    localparam int CLOCKS_PER_INSN = 4;
    localparam int SLOW_OP_CLOCKS = 16;
    localparam logic [2:0] FLASH_MULT_LAST = 3'h4;
    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : stp_pkg

//--- hw/stp_divider.sv
// Wrapping up-counter that pulses on terminal count.
// Assumes the enclosing block supplies the count enable and divisor.
`timescale 1ns/1ps
module stp_divider #(
    parameter int W = 8
) (
    // Clock and control
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    // Count input and divisor
    input wire logic step,
    input wire logic [W-1:0] divisor,
    // Tick out
    output logic tick
);
    logic [W-1:0] cnt_reg;
    logic [W-1:0] cnt_next;
    logic tick_reg;
    logic tick_next;

    // Count up to divisor, then wrap and pulse
    always_comb begin
        cnt_next = cnt_reg;
        tick_next = 1'b0;
        if (step) begin
            if (cnt_reg >= divisor) begin
                cnt_next = '0;
                tick_next = 1'b1;
            end else begin
                cnt_next = cnt_reg + 1'b1;
            end
        end
    end

    // State registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_reg <= '0;
            tick_reg <= 1'b0;
        end else if (ce) begin
            cnt_reg <= cnt_next;
            tick_reg <= tick_next;
        end
    end

    assign tick = tick_reg;
endmodule : stp_divider

//--- hw/stp_top.sv
// System tick prescaler chain with AXI4-Lite register access.
// Assumes one synchronous 20 MHz clock and an AXI4-Lite master.
`timescale 1ns/1ps
module stp_top (
    // Clock, reset, enable
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic clk_en,
    // AXI4-Lite write
    input wire logic [stp_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [stp_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Tick outputs
    output logic insn_strobe,
    output logic us_tick,
    output logic pwm_clk,
    output logic flash_write_clk,
    output logic flash_erase_tick,
    output logic tenth_second_tick,
    output logic ms_irq
);
    import stp_pkg::*;

    // Decode a byte address into a register index
    function automatic logic [7:0] reg_index(input logic [ADDR_W-1:0] a);
        reg_index = a[ADDR_W-1:2];
    endfunction : reg_index

    // Register file
    logic [7:0] ms_irq_interval_reg, ms_irq_interval_next;
    logic [7:0] us_divisor_reg, us_divisor_next;
    logic [15:0] ms_divisor_reg, ms_divisor_next;
    logic [7:0] tenth_second_divisor_reg, tenth_second_divisor_next;
    logic [7:0] flash_timing_ctrl_reg, flash_timing_ctrl_next;
    logic [7:0] pwm_control_reg, pwm_control_next;
    logic [15:0] pwm_period_reg, pwm_period_next;
    logic [7:0] aux_irq_enable_reg, aux_irq_enable_next;
    logic [7:0] ext_irq_control_reg, ext_irq_control_next;
    logic [6:0] ms_pending_reg, ms_pending_next;
    logic pending_valid_reg, pending_valid_next;
    // Bus state; both ready signals pulse for one clock from flops
    logic wr_ready_reg, wr_ready_next;
    logic ar_ready_reg, ar_ready_next;
    logic bvalid_reg, bvalid_next;
    logic [1:0] bresp_reg, bresp_next;
    logic rvalid_reg, rvalid_next;
    logic [31:0] rdata_reg, rdata_next;
    logic [1:0] rresp_reg, rresp_next;
    logic wr_fire;
    logic wr_hit;
    logic [7:0] wr_idx;
    logic [7:0] rd_idx;
    // Tick chain state
    logic [1:0] insn_phase_reg, insn_phase_next;
    logic [2:0] flash_mult_reg, flash_mult_next;
    logic [6:0] ms_irq_cnt_reg, ms_irq_cnt_next;
    logic ms_irq_reg, ms_irq_next;
    logic insn_reg, insn_next;
    logic us_out_reg, ms_out_reg, tenth_out_reg;
    logic pwm_out_reg, flash_out_reg;
    logic us_raw, ms_raw, tenth_raw, pwm_raw, flash_raw;
    logic flash_step;
    logic ms_expire;
    logic pwm_src;

    // Write path: ready rises once address and data are both offered
    assign wr_fire = wr_ready_reg && s_axi_awvalid && s_axi_wvalid;
    assign wr_idx = reg_index(s_axi_awaddr);
    assign rd_idx = reg_index(s_axi_araddr);
    always_comb begin
        wr_ready_next = 1'b0;
        bvalid_next = bvalid_reg;
        bresp_next = bresp_reg;
        if (wr_fire) begin
            bvalid_next = 1'b1;
            bresp_next = wr_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (bvalid_reg && s_axi_bready) begin
            bvalid_next = 1'b0;
        end else if (!bvalid_reg && !wr_ready_reg) begin
            wr_ready_next = s_axi_awvalid && s_axi_wvalid;
        end
    end

    // Read path: ready pulse, then one-cycle register read, SLVERR when unmapped
    always_comb begin
        ar_ready_next = 1'b0;
        rvalid_next = rvalid_reg;
        rdata_next = rdata_reg;
        rresp_next = rresp_reg;
        if (ar_ready_reg && s_axi_arvalid) begin
            rvalid_next = 1'b1;
            rresp_next = RESP_OKAY;
            rdata_next = 32'h0000_0000;
            unique case (rd_idx)
                ADDR_MS_IRQ_INTERVAL_IDX: rdata_next[6:0] = ms_irq_interval_reg[6:0];
                ADDR_US_DIVISOR_IDX: rdata_next[7:0] = us_divisor_reg;
                ADDR_MS_DIVISOR_LOW_IDX: rdata_next[7:0] = ms_divisor_reg[7:0];
                ADDR_MS_DIVISOR_HIGH_IDX: rdata_next[7:0] = ms_divisor_reg[15:8];
                ADDR_TENTH_SECOND_DIVISOR_IDX: rdata_next[7:0] = tenth_second_divisor_reg;
                ADDR_FLASH_TIMING_CTRL_IDX: rdata_next[7:0] = flash_timing_ctrl_reg;
                ADDR_PWM_CONTROL_IDX: rdata_next[7:0] = pwm_control_reg;
                ADDR_PWM_PERIOD_LOW_IDX: rdata_next[7:0] = pwm_period_reg[7:0];
                ADDR_PWM_PERIOD_HIGH_IDX: rdata_next[7:0] = pwm_period_reg[15:8];
                ADDR_AUX_IRQ_ENABLE_IDX: rdata_next[7:0] = aux_irq_enable_reg;
                ADDR_EXT_IRQ_CONTROL_IDX: rdata_next[7:0] = ext_irq_control_reg;
                ADDR_TICK_STATUS_IDX: rdata_next[7:0] = {ms_irq_cnt_reg, ms_irq_reg};
                default: rresp_next = RESP_SLVERR;
            endcase
        end else if (rvalid_reg && s_axi_rready) begin
            rvalid_next = 1'b0;
        end else if (!rvalid_reg && !ar_ready_reg) begin
            ar_ready_next = s_axi_arvalid;
        end
    end

    // Register writes; interval write picks immediate or deferred load
    always_comb begin
        ms_irq_interval_next = ms_irq_interval_reg;
        us_divisor_next = us_divisor_reg;
        ms_divisor_next = ms_divisor_reg;
        tenth_second_divisor_next = tenth_second_divisor_reg;
        flash_timing_ctrl_next = flash_timing_ctrl_reg;
        pwm_control_next = pwm_control_reg;
        pwm_period_next = pwm_period_reg;
        aux_irq_enable_next = aux_irq_enable_reg;
        ext_irq_control_next = ext_irq_control_reg;
        ms_pending_next = ms_pending_reg;
        pending_valid_next = pending_valid_reg;
        wr_hit = 1'b1;
        if (ms_expire && pending_valid_reg) begin
            ms_irq_interval_next = {1'b0, ms_pending_reg};
            pending_valid_next = 1'b0;
        end
        if (wr_fire && s_axi_wstrb[0]) begin
            unique case (wr_idx)
                ADDR_MS_IRQ_INTERVAL_IDX: begin
                    if (s_axi_wdata[MS_IRQ_LOAD_NOW_BIT]) begin
                        ms_irq_interval_next = {1'b0, s_axi_wdata[6:0]};
                        pending_valid_next = 1'b0;
                    end else begin
                        ms_pending_next = s_axi_wdata[6:0];
                        pending_valid_next = 1'b1;
                    end
                end
                ADDR_US_DIVISOR_IDX: us_divisor_next = s_axi_wdata[7:0];
                ADDR_MS_DIVISOR_LOW_IDX: ms_divisor_next[7:0] = s_axi_wdata[7:0];
                ADDR_MS_DIVISOR_HIGH_IDX: ms_divisor_next[15:8] = s_axi_wdata[7:0];
                ADDR_TENTH_SECOND_DIVISOR_IDX: tenth_second_divisor_next = s_axi_wdata[7:0];
                ADDR_FLASH_TIMING_CTRL_IDX: flash_timing_ctrl_next = s_axi_wdata[7:0];
                ADDR_PWM_CONTROL_IDX: pwm_control_next = s_axi_wdata[7:0];
                ADDR_PWM_PERIOD_LOW_IDX: pwm_period_next[7:0] = s_axi_wdata[7:0];
                ADDR_PWM_PERIOD_HIGH_IDX: pwm_period_next[15:8] = s_axi_wdata[7:0];
                ADDR_AUX_IRQ_ENABLE_IDX: aux_irq_enable_next = s_axi_wdata[7:0];
                ADDR_EXT_IRQ_CONTROL_IDX: ext_irq_control_next = s_axi_wdata[7:0];
                ADDR_TICK_STATUS_IDX: wr_hit = 1'b0;
                default: wr_hit = 1'b0;
            endcase
        end else if (wr_fire) begin
            wr_hit = 1'b0;
        end
    end

    // Instruction strobe every four clocks, no other length offered
    always_comb begin
        insn_phase_next = insn_phase_reg + 2'h1;
        insn_next = (insn_phase_reg == INSN_PHASE_LAST);
    end

    // Divider chain
    stp_divider #(.W(8)) u_us (
        .aclk(aclk), .aresetn(aresetn), .ce(clk_en),
        .step(1'b1), .divisor(us_divisor_reg), .tick(us_raw)
    );
    stp_divider #(.W(16)) u_ms (
        .aclk(aclk), .aresetn(aresetn), .ce(clk_en),
        .step(1'b1), .divisor(ms_divisor_reg), .tick(ms_raw)
    );
    stp_divider #(.W(8)) u_tenth (
        .aclk(aclk), .aresetn(aresetn), .ce(clk_en),
        .step(ms_raw), .divisor(tenth_second_divisor_reg), .tick(tenth_raw)
    );
    // PWM source: microsecond tick when select clear, else system clock
    assign pwm_src = pwm_control_reg[PWM_CLK_SELECT_BIT] ? 1'b1 : us_raw;
    stp_divider #(.W(16)) u_pwm (
        .aclk(aclk), .aresetn(aresetn), .ce(clk_en),
        .step(pwm_src), .divisor(pwm_period_reg), .tick(pwm_raw)
    );
    // Flash write: times-five prescale then field-plus-one
    assign flash_step = us_raw && (flash_mult_reg == FLASH_MULT_LAST);
    stp_divider #(.W(4)) u_flash (
        .aclk(aclk), .aresetn(aresetn), .ce(clk_en),
        .step(flash_step), .divisor(flash_timing_ctrl_reg[FLASH_TIMING_MSB:0]),
        .tick(flash_raw)
    );

    // Times-five prescale and millisecond interrupt interval
    assign ms_expire = ms_raw && (ms_irq_cnt_reg >= ms_irq_interval_reg[6:0]);
    always_comb begin
        flash_mult_next = flash_mult_reg;
        if (us_raw) begin
            flash_mult_next = (flash_mult_reg == FLASH_MULT_LAST) ? 3'h0 : flash_mult_reg + 3'h1;
        end
        ms_irq_cnt_next = ms_irq_cnt_reg;
        if (ms_expire) begin
            ms_irq_cnt_next = 7'h00;
        end else if (ms_raw) begin
            ms_irq_cnt_next = ms_irq_cnt_reg + 7'h01;
        end
        ms_irq_next = ms_expire && aux_irq_enable_reg[MS_IRQ_ENABLE_BIT]
            && ext_irq_control_reg[AUX_IRQ_GLOBAL_ENABLE_BIT];
    end

    // All registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ms_irq_interval_reg <= REG_RESET;
            us_divisor_reg <= US_DIVISOR_RESET;
            ms_divisor_reg <= MS_DIVISOR_RESET;
            tenth_second_divisor_reg <= TENTH_RESET;
            flash_timing_ctrl_reg <= REG_RESET;
            pwm_control_reg <= REG_RESET;
            pwm_period_reg <= 16'h0000;
            aux_irq_enable_reg <= REG_RESET;
            ext_irq_control_reg <= REG_RESET;
            ms_pending_reg <= 7'h00;
            pending_valid_reg <= 1'b0;
            wr_ready_reg <= 1'b0;
            ar_ready_reg <= 1'b0;
            bvalid_reg <= 1'b0;
            bresp_reg <= RESP_OKAY;
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
            rresp_reg <= RESP_OKAY;
            insn_phase_reg <= 2'h0;
            insn_reg <= 1'b0;
            flash_mult_reg <= 3'h0;
            ms_irq_cnt_reg <= 7'h00;
            ms_irq_reg <= 1'b0;
            us_out_reg <= 1'b0;
            ms_out_reg <= 1'b0;
            tenth_out_reg <= 1'b0;
            pwm_out_reg <= 1'b0;
            flash_out_reg <= 1'b0;
        end else if (clk_en) begin
            ms_irq_interval_reg <= ms_irq_interval_next;
            us_divisor_reg <= us_divisor_next;
            ms_divisor_reg <= ms_divisor_next;
            tenth_second_divisor_reg <= tenth_second_divisor_next;
            flash_timing_ctrl_reg <= flash_timing_ctrl_next;
            pwm_control_reg <= pwm_control_next;
            pwm_period_reg <= pwm_period_next;
            aux_irq_enable_reg <= aux_irq_enable_next;
            ext_irq_control_reg <= ext_irq_control_next;
            ms_pending_reg <= ms_pending_next;
            pending_valid_reg <= pending_valid_next;
            wr_ready_reg <= wr_ready_next;
            ar_ready_reg <= ar_ready_next;
            bvalid_reg <= bvalid_next;
            bresp_reg <= bresp_next;
            rvalid_reg <= rvalid_next;
            rdata_reg <= rdata_next;
            rresp_reg <= rresp_next;
            insn_phase_reg <= insn_phase_next;
            insn_reg <= insn_next;
            flash_mult_reg <= flash_mult_next;
            ms_irq_cnt_reg <= ms_irq_cnt_next;
            ms_irq_reg <= ms_irq_next;
            us_out_reg <= us_raw;
            ms_out_reg <= ms_raw;
            tenth_out_reg <= tenth_raw;
            pwm_out_reg <= pwm_raw;
            flash_out_reg <= flash_raw;
        end
    end

    // Bus and tick outputs, all from flops
    assign s_axi_awready = wr_ready_reg;
    assign s_axi_wready = wr_ready_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_arready = ar_ready_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;
    assign insn_strobe = insn_reg;
    assign us_tick = us_out_reg;
    assign pwm_clk = pwm_out_reg;
    assign flash_write_clk = flash_out_reg;
    assign flash_erase_tick = ms_out_reg;
    assign tenth_second_tick = tenth_out_reg;
    assign ms_irq = ms_irq_reg;

    // Checks
    sequence ms_tick_s;
        ms_raw && clk_en;
    endsequence
    sequence ms_expire_s;
        ms_expire && clk_en;
    endsequence
    insn_four_clocks_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (insn_strobe && clk_en) |-> (insn_phase_reg == 2'h0))
        else $error("instruction strobe out of phase");
    insn_spacing_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (insn_strobe && clk_en) |=> !insn_strobe)
        else $error("instruction strobe wider than one clock");
    irq_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
        ms_irq |-> $past(aux_irq_enable_reg[MS_IRQ_ENABLE_BIT])
            && $past(ext_irq_control_reg[AUX_IRQ_GLOBAL_ENABLE_BIT]))
        else $error("ms irq without both enables");
    irq_interval_a: assert property (@(posedge aclk) disable iff (!aresetn)
        ms_expire_s |=> (ms_irq_cnt_reg == 7'h00))
        else $error("interval counter not cleared at expiry");
    ms_reload_a: assert property (@(posedge aclk) disable iff (!aresetn)
        ms_tick_s ##1 clk_en |-> !ms_raw || (ms_divisor_reg == 16'h0000))
        else $error("ms tick repeated too soon");
    tenth_from_ms_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (tenth_raw && clk_en) |-> $past(ms_raw))
        else $error("tenth tick without ms tick");
endmodule : stp_top

//--- dv/stp_tb.sv
// Self-checking bench for the tick prescaler chain.
// Drives the AXI4-Lite port itself; 20 MHz clock, sync active-low reset.
`timescale 1ns/1ps
module testbench;
    import stp_pkg::*;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic clk_en = 1'b1;
    logic [ADDR_W-1:0] awaddr = '0;
    logic [ADDR_W-1:0] araddr = '0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = '0;
    logic [3:0] wstrb = '0;
    wire logic awready, wready, bvalid, arready, rvalid;
    wire logic [1:0] bresp, rresp;
    wire logic [31:0] rdata;
    wire logic [6:0] tk;
    int miscompares = 0;
    int cmp_count = 0;
    int seed = 12335;
    int us, ms, pp, ft, p, n;
    logic [31:0] rd;
    logic [1:0] rs;
    time t0, t1;
    logic [7:0] ri [5] = '{ADDR_MS_IRQ_INTERVAL_IDX, ADDR_US_DIVISOR_IDX,
        ADDR_MS_DIVISOR_LOW_IDX, ADDR_MS_DIVISOR_HIGH_IDX, ADDR_TENTH_SECOND_DIVISOR_IDX};
    logic [31:0] rv [5] = '{32'h0, 32'(US_DIVISOR_RESET), 32'(MS_DIVISOR_RESET[7:0]),
        32'(MS_DIVISOR_RESET[15:8]), 32'(TENTH_RESET)};

    // Clock at 50 ns period
    always #25 aclk = ~aclk;

    stp_top u_dut (
        .aclk(aclk), .aresetn(aresetn), .clk_en(clk_en),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .insn_strobe(tk[0]), .us_tick(tk[1]), .pwm_clk(tk[2]), .flash_write_clk(tk[3]),
        .flash_erase_tick(tk[4]), .tenth_second_tick(tk[5]), .ms_irq(tk[6])
    );

    // Verdict and end of run
    task automatic results;
        $display("compares %0d miscompares %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : results

    // Compare with case equality
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %0t %s got %0h exp %0h", $time, m, got, exp);
        end
    endtask : chk

    // AXI write; address and data offered together, bready held until bvalid
    task automatic wr(input logic [7:0] i, input logic [31:0] d, output logic [1:0] r);
        bit done;
        int k;
        done = 0;
        k = 0;
        r = 2'h3;
        @(posedge aclk);
        awaddr <= {i, 2'b00};
        awvalid <= 1'b1;
        wdata <= d;
        wstrb <= 4'hf;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            k++;
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) begin
                r = bresp;
                bready <= 1'b0;
                done = 1;
            end
        end while (!done && k < 200);
    endtask : wr

    // AXI read; rready held until rvalid, arvalid until arready
    task automatic rdr(input logic [7:0] i, output logic [31:0] d, output logic [1:0] r);
        bit got, aok;
        int k;
        got = 0;
        aok = 0;
        k = 0;
        r = 2'h3;
        d = '0;
        @(posedge aclk);
        araddr <= {i, 2'b00};
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            k++;
            if (arready && !aok) begin
                arvalid <= 1'b0;
                aok = 1;
            end
            if (rvalid && !got) begin
                d = rdata;
                r = rresp;
                rready <= 1'b0;
                got = 1;
            end
        end while (!(got && aok) && k < 200);
    endtask : rdr

    // Write expecting an OKAY response
    task automatic w(input logic [7:0] i, input logic [31:0] d);
        wr(i, d, rs);
        chk(32'(rs), 32'(RESP_OKAY), "write resp");
    endtask : w

    // Wait for a tick, note its time, then see it drop after one clock
    task automatic pulse(input int s, output time t);
        int k;
        k = 0;
        do begin
            @(negedge aclk);
            k++;
        end while (tk[s] !== 1'b1 && k < 20000);
        t = $time;
        @(negedge aclk);
        chk(32'(tk[s]), 32'h0, "pulse width");
    endtask : pulse

    // Clocks between two successive ticks
    task automatic per(input int s, output int c);
        time a, b;
        pulse(s, a);
        pulse(s, b);
        c = int'((b - a) / 50);
    endtask : per

    // Watchdog against hangs
    initial begin
        #(80000 * 50);
        miscompares++;
        results();
    end

    // Main sequence
    initial begin
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        for (int i = 0; i < 5; i++) begin
            rdr(ri[i], rd, rs);
            chk(rd, rv[i], "reset value");
        end
        rdr(8'h10, rd, rs);
        chk(32'(rs), 32'(RESP_SLVERR), "unmapped read");
        wr(8'h10, 32'h5, rs);
        chk(32'(rs), 32'(RESP_SLVERR), "unmapped write");
        wr(ADDR_TICK_STATUS_IDX, 32'h1, rs);
        chk(32'(rs), 32'(RESP_SLVERR), "status write");
        per(0, p);
        chk(p, CLOCKS_PER_INSN, "insn cycle");
        us = ($random(seed) & 7) + 1;
        ms = ($random(seed) & 15) + 8;
        pp = ($random(seed) & 7) + 1;
        ft = 5 + (($random(seed) & 255) % 3);
        w(ADDR_US_DIVISOR_IDX, us);
        w(ADDR_MS_DIVISOR_LOW_IDX, ms);
        w(ADDR_MS_DIVISOR_HIGH_IDX, 0);
        w(ADDR_TENTH_SECOND_DIVISOR_IDX, 2);
        rdr(ADDR_US_DIVISOR_IDX, rd, rs);
        chk(rd, us, "us readback");
        per(1, p);
        chk(p, us + 1, "us tick");
        per(4, p);
        chk(p, ms + 1, "ms tick");
        per(5, p);
        chk(p, 3 * (ms + 1), "tenth tick");
        w(ADDR_FLASH_TIMING_CTRL_IDX, 32'hf0 | ft);
        per(3, p);
        chk(p, (ft + 1) * 5 * (us + 1), "flash write clk");
        w(ADDR_PWM_PERIOD_LOW_IDX, pp);
        w(ADDR_PWM_PERIOD_HIGH_IDX, 0);
        w(ADDR_PWM_CONTROL_IDX, 0);
        per(2, p);
        chk(p, (pp + 1) * (us + 1), "pwm from us");
        w(ADDR_PWM_CONTROL_IDX, 8);
        per(2, p);
        chk(p, pp + 1, "pwm from clk");
        // Each enable alone must keep the interrupt quiet
        w(ADDR_MS_IRQ_INTERVAL_IDX, 32'h83);
        for (int e = 0; e < 2; e++) begin
            w(ADDR_AUX_IRQ_ENABLE_IDX, e ? 32'h0 : 32'h10);
            w(ADDR_EXT_IRQ_CONTROL_IDX, e ? 32'h20 : 32'h0);
            n = 0;
            repeat (300) @(negedge aclk) if (tk[6] === 1'b1) n++;
            chk(n, 0, "irq masked");
        end
        w(ADDR_AUX_IRQ_ENABLE_IDX, 32'h10);
        per(6, p);
        chk(p, 4 * (ms + 1), "irq period");
        // Deferred load keeps the running interval
        w(ADDR_MS_IRQ_INTERVAL_IDX, 20);
        pulse(6, t0);
        pulse(6, t0);
        w(ADDR_MS_IRQ_INTERVAL_IDX, 1);
        pulse(6, t1);
        chk(32'((t1 - t0) / 50), 21 * (ms + 1), "deferred load");
        per(6, p);
        chk(p, 2 * (ms + 1), "new interval");
        // Immediate loads at both interval bounds
        foreach (ri[i]) if (i < 2) begin
            w(ADDR_MS_IRQ_INTERVAL_IDX, i ? 32'hff : 32'h80);
            per(6, p);
            chk(p, (i ? 128 : 1) * (ms + 1), "immediate load");
        end
        results();
    end
endmodule : testbench
